/* hw/scs_clock_select.sv */
// system clock source and post-divider selection with switch sequencing
// assumes fuse inputs are stable from reset release and ready inputs
// are synchronous to CLK_IN
//
// Summary of operation
// - bit 7 of request and current reads zero
// - request bits 6..4 pick the source
// - source caught from reset fuses after reset
// - request bits 3..0 pick the divider
// - reserved source write is dropped whole
// - switch fuse low makes request read-only
// - divider resets 0010 for fast source, else 0000
// - current bits 6..4 show source in use
// - current bits 3..0 show divider in use
// - current resets equal to request
// - current holds start-up selection when code begins
// - codes 111,110,101,100 select the plain oscillators
// - 010 external with PLL, 001 fast with PLL
// - external mode taken from external mode fuse
// - fast oscillator frequency from its frequency field
// - divider codes 0..9 divide by powers of two
// - old selection runs until new source ready, except for a request written on the wait-to-ready step
// - hold keeps old selection even when ready
// - switch updates current, sets ready, clears new-ready
// - ready high only when current equals request
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select import scs_pkg::*; #(
	parameter int EXT_MODE_W = 3, // external mode fuse width
	parameter int FREQ_W     = 4  // fast oscillator frequency field width
) (
	input  wire logic                  CLK_IN,                   // system clock
	input  wire logic                  RST_N_IN,                 // async reset, low
	input  wire logic                  CE_IN,                    // clock enable
	input  wire logic [1:0]            ADDR_IN,                  // register index
	input  wire logic [7:0]            WDATA_IN,                 // write data
	input  wire logic                  WR_IN,                    // write strobe
	input  wire logic                  RD_IN,                    // read strobe
	input  wire logic [2:0]            RESET_SOURCE_FUSE_IN,     // reset source
	input  wire logic                  SWITCH_ENABLE_FUSE_IN,    // switching allowed
	input  wire logic [EXT_MODE_W-1:0] EXTERNAL_MODE_FUSE_IN,    // external mode
	input  wire logic [FREQ_W-1:0]     FAST_OSC_FREQUENCY_IN,    // frequency field
	input  wire logic [SCS_OSC_N-1:0]  OSC_READY_IN,             // oscillator ready
	output logic      [7:0]            RDATA_OUT,                // read data
	output logic      [2:0]            CURRENT_SOURCE_OUT,       // source in use
	output logic      [3:0]            CURRENT_DIVIDER_OUT,      // divider in use
	output logic      [SCS_DIV_STEPS-1:0] DIVIDE_RATIO_OUT,      // one-hot ratio
	output logic      [SCS_OSC_N-1:0]  OSC_ENABLE_OUT,           // oscillators on
	output logic      [EXT_MODE_W-1:0] EXTERNAL_MODE_OUT,        // external mode
	output logic      [FREQ_W-1:0]     FAST_OSC_FREQUENCY_OUT,   // fast frequency
	output logic                       SELECTION_READY_OUT,      // current equals request
	output logic                       NEW_SOURCE_READY_OUT      // new source ready
);
	//==========================================================
	// declarations
	//==========================================================
	scs_sel_type                   request_q;    // requested selection
	scs_sel_type                   request_d;    // its next value
	scs_sel_type                   current_q;    // selection in use
	scs_sel_type                   current_d;    // its next value
	scs_sel_type                   fuse_sel;     // start-up selection from fuses
	scs_state_type                 state_q;      // switch sequencer
	scs_state_type                 state_d;      // its next state
	logic                          init_q;       // fuses have been caught
	logic                          hold_q;       // switch hold control
	logic                          sready_q;     // selection ready flag
	logic                          nready_q;     // new source ready flag
	logic [SCS_OSC_N-1:0]          req_en;       // oscillators for request
	logic [SCS_OSC_N-1:0]          cur_en;       // oscillators for current
	logic [SCS_OSC_N-1:0]          cur_en_d;     // oscillators for next current
	logic [SCS_DIV_STEPS-1:0]      ratio_d;      // ratio of next current
	logic                          wsrc_valid;   // written source not reserved
	logic                          write_req;    // legal request write
	logic                          write_status; // status write
	logic                          req_ready;    // requested oscillators all ready
	logic                          differ;       // request differs from current
	logic                          do_switch;    // switch takes effect now
	logic [7:0]                    rd_mux;       // read data selection

	//==========================================================
	// decoders
	//==========================================================
	// oscillators needed by the request
	scs_source_decode u_req_dec (
		.src_in     (request_q.src),
		.osc_en_out (req_en),
		.valid_out  ()
	);
	// oscillators of the current selection
	scs_source_decode u_cur_dec (
		.src_in     (current_q.src),
		.osc_en_out (cur_en),
		.valid_out  ()
	);
	// oscillators of the next current selection
	scs_source_decode u_nxt_dec (
		.src_in     (current_d.src),
		.osc_en_out (cur_en_d),
		.valid_out  ()
	);
	// validity of the source in the write data
	scs_source_decode u_wr_dec (
		.src_in     (WDATA_IN[SCS_SRC_LSB +: 3]),
		.osc_en_out (),
		.valid_out  (wsrc_valid)
	);
	// divide ratio of the next current selection
	scs_divider_decode #(
		.STEPS (SCS_DIV_STEPS)
	) u_div_dec (
		.div_in    (current_d.div),
		.ratio_out (ratio_d)
	);

	//==========================================================
	// request and selection next values
	//==========================================================
	// start-up selection: fuse source, divider picked by source
	always_comb begin
		fuse_sel.src = RESET_SOURCE_FUSE_IN;
		if (RESET_SOURCE_FUSE_IN == SCS_SRC_FAST) begin
			fuse_sel.div = SCS_DIV_FAST_RST;
		end else begin
			fuse_sel.div = SCS_DIV_RST;
		end
	end

	// a request write needs the switch fuse and a legal source
	assign write_req = WR_IN && (ADDR_IN == SCS_IDX_REQUEST)
		&& SWITCH_ENABLE_FUSE_IN
		&& wsrc_valid;
	assign write_status = WR_IN && (ADDR_IN == SCS_IDX_STATUS);
	// every oscillator the request needs must report ready
	assign req_ready = &(~req_en | OSC_READY_IN);
	assign differ    = (request_q != current_q);
	// switch once ready and not held; a write in the ready state restarts the wait
	assign do_switch = (state_q == SCS_ST_READY) && differ
		&& !write_req && !hold_q;

	// next request value
	always_comb begin
		request_d = request_q;
		if (!init_q) begin
			request_d = fuse_sel;
		end else if (write_req) begin
			request_d.src = WDATA_IN[SCS_SRC_LSB +: 3];
			request_d.div = WDATA_IN[SCS_DIV_LSB +: 4];
		end
	end

	// next current value
	always_comb begin
		current_d = current_q;
		if (!init_q) begin
			current_d = fuse_sel;
		end else if (do_switch) begin
			current_d = request_q;
		end
	end

	// switch sequencer next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			SCS_ST_IDLE: begin
				if (init_q && differ) begin
					state_d = SCS_ST_WAIT;
				end
			end
			SCS_ST_WAIT: begin
				if (!differ) begin
					state_d = SCS_ST_IDLE; // request abandoned
				end else if (req_ready) begin
					state_d = SCS_ST_READY;
				end
			end
			SCS_ST_READY: begin
				if (!differ) begin
					state_d = SCS_ST_IDLE; // abandoned by copying back
				end else if (write_req) begin
					state_d = SCS_ST_WAIT; // new target, check again
				end else if (!hold_q) begin
					state_d = SCS_ST_IDLE;
				end
			end
			default: state_d = SCS_ST_IDLE;
		endcase
	end

	//==========================================================
	// state registers
	//==========================================================
	// start-up catch of the fuses, one edge after release
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			init_q <= 1'b0;
		end else if (CE_IN) begin
			init_q <= 1'b1;
		end
	end

	// request register
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			request_q <= SCS_SEL_RST;
		end else if (CE_IN) begin
			request_q <= request_d;
		end
	end

	// current selection register
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			current_q <= SCS_SEL_RST;
		end else if (CE_IN) begin
			current_q <= current_d;
		end
	end

	// hold control, software owned
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			hold_q <= 1'b0;
		end else if (CE_IN && write_status) begin
			hold_q <= WDATA_IN[SCS_HOLD_BIT];
		end
	end

	// sequencer state
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_q <= SCS_ST_IDLE;
		end else if (CE_IN) begin
			state_q <= state_d;
		end
	end

	// status flags follow the next values, so they never lag
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sready_q <= 1'b1;
			nready_q <= 1'b0;
		end else if (CE_IN) begin
			sready_q <= (request_d == current_d);
			nready_q <= (state_d == SCS_ST_READY);
		end
	end

	//==========================================================
	// register read port
	//==========================================================
	// read selection; unused bits and unmapped indexes read zero
	always_comb begin
		rd_mux = 8'h00;
		case (ADDR_IN)
			SCS_IDX_REQUEST: rd_mux = {1'b0, request_q};
			SCS_IDX_CURRENT: rd_mux = {1'b0, current_q};
			SCS_IDX_STATUS: begin
				rd_mux[SCS_HOLD_BIT]   = hold_q;
				rd_mux[SCS_SREADY_BIT] = sready_q;
				rd_mux[SCS_NREADY_BIT] = nready_q;
			end
			default: rd_mux = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			RDATA_OUT <= 8'h00;
		end else if (CE_IN) begin
			RDATA_OUT <= RD_IN ? rd_mux : 8'h00;
		end
	end

	//==========================================================
	// clock control outputs
	//==========================================================
	// selection, ratio and oscillator controls
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			CURRENT_SOURCE_OUT     <= SCS_SEL_RST.src;
			CURRENT_DIVIDER_OUT    <= SCS_SEL_RST.div;
			DIVIDE_RATIO_OUT       <= '0;
			OSC_ENABLE_OUT         <= '0;
			EXTERNAL_MODE_OUT      <= '0;
			FAST_OSC_FREQUENCY_OUT <= '0;
		end else if (CE_IN) begin
			CURRENT_SOURCE_OUT  <= current_d.src;
			CURRENT_DIVIDER_OUT <= current_d.div;
			DIVIDE_RATIO_OUT    <= ratio_d;
			// keep the old source running while the new one starts
			OSC_ENABLE_OUT      <= cur_en_d
				| ((state_d != SCS_ST_IDLE) ? req_en : '0);
			EXTERNAL_MODE_OUT   <= cur_en_d[SCS_OSC_EXT]
				? EXTERNAL_MODE_FUSE_IN : '0;
			FAST_OSC_FREQUENCY_OUT <= cur_en_d[SCS_OSC_FAST]
				? FAST_OSC_FREQUENCY_IN : '0;
		end
	end

	assign SELECTION_READY_OUT  = sready_q;
	assign NEW_SOURCE_READY_OUT = nready_q;

	//==========================================================
	// assertions
	//==========================================================
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	// a legal write step
	sequence s_legal_write;
		CE_IN && init_q && write_req;
	endsequence
	// an illegal request write step
	sequence s_dropped_write;
		CE_IN && init_q && WR_IN && (ADDR_IN == SCS_IDX_REQUEST) && !write_req;
	endsequence

	a_bit7_zero: assert property (
		(CE_IN && RD_IN && (ADDR_IN != SCS_IDX_STATUS)) |=> !RDATA_OUT[7])
		else $error("request or current bit 7 read as one");
	a_write_visible: assert property (
		s_legal_write |=> (request_q == $past(WDATA_IN[6:0])))
		else $error("legal request write not stored");
	a_reserved_drop: assert property (
		s_dropped_write |=> $stable(request_q))
		else $error("dropped request write changed the request");
	a_fuse_lock: assert property (
		(init_q && !SWITCH_ENABLE_FUSE_IN) |=> $stable(request_q))
		else $error("request changed with switching disabled");
	a_fuse_catch: assert property (
		(CE_IN && !init_q) |=> (request_q.src == $past(RESET_SOURCE_FUSE_IN))
			&& (current_q == request_q))
		else $error("start-up selection not taken from fuses");
	a_reset_div: assert property (
		(CE_IN && !init_q) |=> (request_q.div ==
			((request_q.src == SCS_SRC_FAST) ? SCS_DIV_FAST_RST : SCS_DIV_RST)))
		else $error("start-up divider wrong");
	a_wait_ready: assert property (
		(init_q && differ && !req_ready && state_q != SCS_ST_READY)
			|=> $stable(current_q))
		else $error("switched before the new source was ready");
	a_hold_keeps: assert property (
		(init_q && hold_q && !write_status) [*2] |=> $stable(current_q))
		else $error("current changed while held");
	a_switch_flags: assert property (
		(CE_IN && do_switch) |=> (current_q == $past(request_q))
			&& sready_q && !nready_q)
		else $error("switch did not update current and flags");
	a_ready_match: assert property (
		init_q |-> (sready_q == (request_q == current_q)))
		else $error("selection ready does not match compare");
	a_out_mirror: assert property (
		init_q |-> (CURRENT_SOURCE_OUT == current_q.src)
			&& (CURRENT_DIVIDER_OUT == current_q.div))
		else $error("current outputs differ from register");
endmodule
`default_nettype wire

/* inc/scs_pkg.sv */
// package for the system clock source and divider select block
// assumes one system clock domain; no bus beyond the plain register port
`default_nettype none
//==========================================================
// constants and types
//==========================================================
package scs_pkg;
	// register indexes on the plain register port
	localparam logic [1:0] SCS_IDX_REQUEST = 2'h0;
	localparam logic [1:0] SCS_IDX_CURRENT = 2'h1;
	localparam logic [1:0] SCS_IDX_STATUS  = 2'h2;
	// field positions
	localparam int SCS_SRC_LSB   = 4;
	localparam int SCS_DIV_LSB   = 0;
	localparam int SCS_HOLD_BIT  = 7;
	localparam int SCS_SREADY_BIT = 4;
	localparam int SCS_NREADY_BIT = 3;
	// source codes
	localparam logic [2:0] SCS_SRC_EXT      = 3'h7;
	localparam logic [2:0] SCS_SRC_FAST     = 3'h6;
	localparam logic [2:0] SCS_SRC_SLOW     = 3'h5;
	localparam logic [2:0] SCS_SRC_SEC      = 3'h4;
	localparam logic [2:0] SCS_SRC_RSVD_HI  = 3'h3;
	localparam logic [2:0] SCS_SRC_EXT_PLL  = 3'h2;
	localparam logic [2:0] SCS_SRC_FAST_PLL = 3'h1;
	localparam logic [2:0] SCS_SRC_RSVD_LO  = 3'h0;
	// divider codes
	localparam logic [3:0] SCS_DIV_FAST_RST = 4'h2;
	localparam logic [3:0] SCS_DIV_RST      = 4'h0;
	localparam int         SCS_DIV_STEPS    = 10;
	// oscillator enable / ready bit positions
	localparam int SCS_OSC_EXT  = 0;
	localparam int SCS_OSC_FAST = 1;
	localparam int SCS_OSC_SLOW = 2;
	localparam int SCS_OSC_SEC  = 3;
	localparam int SCS_OSC_PLL  = 4;
	localparam int SCS_OSC_N    = 5;
	// source plus divider as carried around the block
	typedef struct packed {
		logic [2:0] src;
		logic [3:0] div;
	} scs_sel_type;
	// value held during asynchronous reset, before the fuses are caught
	localparam scs_sel_type SCS_SEL_RST = '{src: SCS_SRC_FAST, div: SCS_DIV_FAST_RST};
	// switch sequencer states
	typedef enum logic [2:0] {
		SCS_ST_IDLE  = 3'b001,
		SCS_ST_WAIT  = 3'b010,
		SCS_ST_READY = 3'b100
	} scs_state_type;
endpackage
`default_nettype wire

/* hw/scs_source_decode.sv */
// decodes a source code into oscillator enables and a valid flag
// assumes purely combinational use inside the selector
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// source decoder
//==========================================================
module scs_source_decode import scs_pkg::*; (
	input  wire logic [2:0]           src_in,    // source code
	output logic      [SCS_OSC_N-1:0] osc_en_out, // oscillators needed
	output logic                      valid_out  // code not reserved
);
	// map code to the oscillators it needs
	always_comb begin
		osc_en_out = '0;
		valid_out  = 1'b1;
		case (src_in)
			SCS_SRC_EXT: osc_en_out[SCS_OSC_EXT] = 1'b1;
			SCS_SRC_FAST: osc_en_out[SCS_OSC_FAST] = 1'b1;
			SCS_SRC_SLOW: osc_en_out[SCS_OSC_SLOW] = 1'b1;
			SCS_SRC_SEC: osc_en_out[SCS_OSC_SEC] = 1'b1;
			SCS_SRC_EXT_PLL: begin
				osc_en_out[SCS_OSC_EXT] = 1'b1;
				osc_en_out[SCS_OSC_PLL] = 1'b1;
			end
			SCS_SRC_FAST_PLL: begin
				osc_en_out[SCS_OSC_FAST] = 1'b1;
				osc_en_out[SCS_OSC_PLL]  = 1'b1;
			end
			default: valid_out = 1'b0; // reserved codes
		endcase
	end
endmodule
`default_nettype wire

/* hw/scs_divider_decode.sv */
// decodes a divider code into a one-hot divide-by-two-power select
// assumes purely combinational use; reserved codes give all zero
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// divider decoder
//==========================================================
module scs_divider_decode import scs_pkg::*; #(
	parameter int STEPS = SCS_DIV_STEPS // number of legal ratios
) (
	input  wire logic [3:0]       div_in,   // divider code
	output logic      [STEPS-1:0] ratio_out // bit n set: divide by 2**n
);
	// one compare per legal ratio
	genvar gi;
	generate
		for (gi = 0; gi < STEPS; gi++) begin : g_ratio
			assign ratio_out[gi] = (div_in == 4'(gi));
		end
	endgenerate
endmodule
`default_nettype wire

/* bench/scs_clock_select_tb.sv */
// self-checking testbench for the clock source and divider select block
// assumes the plain register port, one 20 MHz clock and the status index of the package
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select_tb import scs_pkg::*;;
	//==========================================================
	// bench signals
	//==========================================================
	logic                 clk;         // system clock
	logic                 rst_n;       // async reset, low
	logic                 ce;          // clock enable, high except during the frozen write
	logic [1:0]           addr;        // register index
	logic [7:0]           wdata;       // write data
	logic                 wr;          // write strobe
	logic                 rd;          // read strobe
	logic [2:0]           rst_src;     // reset source fuse
	logic                 sw_en;       // switch enable fuse
	logic [2:0]           ext_mode;    // external mode fuse
	logic [3:0]           fast_frq;    // fast oscillator frequency field
	logic [SCS_OSC_N-1:0] osc_rdy;     // oscillator ready inputs
	logic [7:0]           rdata;       // read data
	logic [2:0]           cur_src;     // source in use
	logic [3:0]           cur_div;     // divider in use
	logic [9:0]           ratio;       // one-hot ratio
	logic [SCS_OSC_N-1:0] osc_en;      // oscillators wanted
	logic [2:0]           ext_out;     // external mode out
	logic [3:0]           frq_out;     // fast frequency out
	logic                 sel_ready;   // current equals request
	logic                 new_ready;   // new source ready
	int                   n_mismatch;  // mismatches counted
	int                   checks;      // comparisons made
	logic [2:0]           src_tab [6]; // legal source codes
	logic [2:0]           s;           // source under test
	//==========================================================
	// design under test
	//==========================================================
	scs_clock_select u_scs_clock_select (
		.CLK_IN                (clk),
		.RST_N_IN              (rst_n),
		.CE_IN                 (ce),
		.ADDR_IN               (addr),
		.WDATA_IN              (wdata),
		.WR_IN                 (wr),
		.RD_IN                 (rd),
		.RESET_SOURCE_FUSE_IN  (rst_src),
		.SWITCH_ENABLE_FUSE_IN (sw_en),
		.EXTERNAL_MODE_FUSE_IN (ext_mode),
		.FAST_OSC_FREQUENCY_IN (fast_frq),
		.OSC_READY_IN          (osc_rdy),
		.RDATA_OUT             (rdata),
		.CURRENT_SOURCE_OUT    (cur_src),
		.CURRENT_DIVIDER_OUT   (cur_div),
		.DIVIDE_RATIO_OUT      (ratio),
		.OSC_ENABLE_OUT        (osc_en),
		.EXTERNAL_MODE_OUT     (ext_out),
		.FAST_OSC_FREQUENCY_OUT(frq_out),
		.SELECTION_READY_OUT   (sel_ready),
		.NEW_SOURCE_READY_OUT  (new_ready)
	);
	//==========================================================
	// clock
	//==========================================================
	// 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	//==========================================================
	// helpers
	//==========================================================
	// compares one value and counts the outcome
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// prints counts and verdict, then stops
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one-cycle write strobe
	task automatic bus_write(input logic [1:0] idx, input logic [7:0] d);
		@(posedge clk);
		addr  <= idx;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	// one-cycle read strobe; data taken in the following cycle only
	task automatic rd_chk(input logic [1:0] idx, input logic [7:0] exp, input string what);
		@(posedge clk);
		addr <= idx;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		check(what, {8'h00, rdata}, {8'h00, exp});
	endtask
	// reset with the given fuses; first access leaves room for the fuse catch
	task automatic do_reset(input logic [2:0] fsrc, input logic fen);
		@(posedge clk);
		rst_n   <= 1'b0;
		rst_src <= fsrc;
		sw_en   <= fen;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// waits a bounded time for the switch to land
	task automatic wait_switch();
		bit done;
		done = 1'b0;
		@(posedge clk);
		#1;
		check("ready during switch", {15'h0, sel_ready}, 16'h0);
		for (int i = 0; i < 20 && !done; i++) begin
			@(posedge clk);
			#1;
			if (sel_ready === 1'b1)
				done = 1'b1;
		end
		if (!done) begin
			n_mismatch++;
			$display("CHECK FAILED switch expected done seen timeout");
			end_of_test();
		end
	endtask
	// oscillators a source code needs
	function automatic logic [SCS_OSC_N-1:0] need(input logic [2:0] c);
		case (c)
			SCS_SRC_EXT:      need = 5'h01;
			SCS_SRC_FAST:     need = 5'h02;
			SCS_SRC_SLOW:     need = 5'h04;
			SCS_SRC_SEC:      need = 5'h08;
			SCS_SRC_EXT_PLL:  need = 5'h11;
			SCS_SRC_FAST_PLL: need = 5'h12;
			default:          need = 5'h00;
		endcase
	endfunction
	//==========================================================
	// main sequence
	//==========================================================
	initial begin
		n_mismatch = 0;
		checks     = 0;
		rst_n      = 1'b0;
		ce         = 1'b1;
		addr       = 2'h0;
		wdata      = 8'h00;
		wr         = 1'b0;
		rd         = 1'b0;
		rst_src    = 3'h6;
		sw_en      = 1'b1;
		ext_mode   = 3'h5;
		fast_frq   = 4'hA;
		osc_rdy    = 5'h00;
		src_tab = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1};
		// fuse reset to the fast source
		do_reset(3'h6, 1'b1);
		rd_chk(SCS_IDX_REQUEST, 8'h62, "request reset");
		rd_chk(SCS_IDX_CURRENT, 8'h62, "current reset");
		check("start-up current", {9'h000, cur_src, cur_div}, 16'h0062);
		@(posedge clk);
		#1;
		check("read data one cycle", {8'h00, rdata}, 16'h0);
		rd_chk(SCS_IDX_STATUS, 8'h10, "status reset");
		rd_chk(2'h3, 8'h00, "unmapped read");
		$display("test reset done");
		// request write, reserved drops, old selection kept while not ready
		bus_write(SCS_IDX_REQUEST, 8'hF5);
		rd_chk(SCS_IDX_REQUEST, 8'h75, "request write");
		bus_write(SCS_IDX_REQUEST, 8'h03);
		bus_write(SCS_IDX_REQUEST, 8'h39);
		bus_write(SCS_IDX_CURRENT, 8'h11);
		rd_chk(SCS_IDX_REQUEST, 8'h75, "reserved source");
		repeat (10) @(posedge clk);
		rd_chk(SCS_IDX_CURRENT, 8'h62, "old selection");
		rd_chk(SCS_IDX_STATUS, 8'h00, "status switching");
		@(posedge clk);
		osc_rdy <= 5'h1F;
		wait_switch();
		rd_chk(SCS_IDX_CURRENT, 8'h75, "current after switch");
		check("divider out", {12'h0, cur_div}, 16'h5);
		rd_chk(SCS_IDX_STATUS, 8'h10, "status switched");
		$display("test switch done");
		// hold keeps the old selection with the new source ready
		bus_write(SCS_IDX_STATUS, 8'h80);
		bus_write(SCS_IDX_REQUEST, 8'h61);
		repeat (8) @(posedge clk);
		rd_chk(SCS_IDX_STATUS, 8'h88, "status on hold");
		rd_chk(SCS_IDX_CURRENT, 8'h75, "current on hold");
		check("new ready on hold", {15'h0, new_ready}, 16'h1);
		bus_write(SCS_IDX_STATUS, 8'h00);
		// the held switch lands on the first edge after the release
		@(posedge clk);
		#1;
		check("switch on release", {15'h0, sel_ready}, 16'h1);
		check("new ready cleared", {15'h0, new_ready}, 16'h0);
		rd_chk(SCS_IDX_CURRENT, 8'h61, "current after hold");
		$display("test hold done");
		// every legal source code; reserved divider codes left out here
		foreach (src_tab[k]) begin
			s = src_tab[k];
			bus_write(SCS_IDX_REQUEST, {1'b0, s, 4'h0});
			wait_switch();
			check("source out", {13'h0, cur_src}, {13'h0, s});
			check("enables", {11'h0, osc_en}, {11'h0, need(s)});
			check("ext mode", {13'h0, ext_out}, (s == 3'h7 || s == 3'h2) ? 16'h5 : 16'h0);
			check("fast freq", {12'h0, frq_out}, (s == 3'h6 || s == 3'h1) ? 16'hA : 16'h0);
		end
		$display("test sources done");
		// every legal divider code; reserved ones are never written
		for (int d = 0; d < 10; d++) begin
			bus_write(SCS_IDX_REQUEST, {4'h5, d[3:0]});
			wait_switch();
			check("divider code", {12'h0, cur_div}, {12'h0, d[3:0]});
			check("ratio", {6'h0, ratio}, (16'h1 << d));
		end
		$display("test dividers done");
		// clock enable low freezes the block, so the hold write is lost
		@(posedge clk);
		ce <= 1'b0;
		bus_write(SCS_IDX_STATUS, 8'h80);
		ce <= 1'b1;
		rd_chk(SCS_IDX_STATUS, 8'h10, "write while frozen");
		$display("test enable done");
		// external fuse reset in mid-run, switching locked
		do_reset(3'h7, 1'b0);
		rd_chk(SCS_IDX_REQUEST, 8'h70, "request ext reset");
		rd_chk(SCS_IDX_CURRENT, 8'h70, "current ext reset");
		bus_write(SCS_IDX_REQUEST, 8'h62);
		rd_chk(SCS_IDX_REQUEST, 8'h70, "locked request");
		check("locked source out", {13'h0, cur_src}, 16'h7);
		$display("test lock done");
		end_of_test();
	end
endmodule
`default_nettype wire
